// >>> esp_bm.sv
// Bus side model: host, DMA controller and glue
`timescale 1ns/1ps
module esp_bm (
  // Clock and bus data
  input wire i_sys_clk,
  input wire [31:0] i_dev_data,
  input wire [3:0] i_dev_oe_n,
  // Bus pins
  output reg [15:2] o_addr,
  output reg [3:0] o_be_n,
  output reg o_aen,
  output reg o_stb_n,
  output reg o_rd_n,
  output reg o_wr_n,
  output reg o_bclk,
  output reg o_ack_n,
  output reg o_dir,
  output reg o_cyc_n,
  output reg o_rdy_n,
  output reg [31:0] o_data
);
  initial
  begin
    o_addr = 14'h0;
    o_be_n = 4'hf;
    o_data = 32'h0;
    {o_aen, o_stb_n, o_rd_n, o_wr_n, o_ack_n, o_cyc_n, o_rdy_n, o_bclk, o_dir} = 9'h1fc;
  end
  // I/O access, read or write strobe held 180ns
  task io(input wr, input [15:2] a, input [3:0] be, input aen, input [31:0] d,
    output [31:0] q, output [3:0] qoe);
  begin
    @(negedge i_sys_clk);
    o_addr = a;
    o_be_n = be;
    o_aen = aen;
    o_data = d;
    o_stb_n = 0;
    repeat (4) @(negedge i_sys_clk);
    o_stb_n = 1;
    repeat (2) @(negedge i_sys_clk);
    {o_rd_n, o_wr_n} = wr ? 2'b10 : 2'b01;
    repeat (36) @(negedge i_sys_clk);
    q = i_dev_data;
    qoe = i_dev_oe_n;
    {o_rd_n, o_wr_n} = 2'b11;
    repeat (8) @(negedge i_sys_clk);
    o_data = ~d;
    o_aen = 1;
  end
  endtask
  // Aligned burst, beat s sent with ready high and not repeated, dr high writes the device
  task dma(input integer n, input integer s, input dr, output [31:0] q);
    integer k;
  begin
    o_ack_n = 0;
    o_dir = dr;
    o_cyc_n = !dr;
    for (k = 0; k < n; k = k + 1)
    begin
      o_rdy_n = (k == s);
      o_data = 32'h5a00_0000 + k;
      repeat (16) @(negedge i_sys_clk);
      o_bclk = 1;
      q = i_dev_data;
      repeat (16) @(negedge i_sys_clk);
      o_bclk = 0;
    end
    o_rdy_n = 1;
    repeat (8) @(negedge i_sys_clk);
    {o_ack_n, o_cyc_n, o_dir} = 3'b110;
    o_data = ~o_data;
    repeat (8) @(negedge i_sys_clk);
  end
  endtask
endmodule // esp_bm

// >>> esp_defs.vh
// Shared constants for the bus slave port
`ifndef ESP_DEFS_VH
`define ESP_DEFS_VH
`define ESP_BE_DWORD 4'b0000
`define ESP_BE_LOWORD 4'b1100
`define ESP_BE_HIWORD 4'b0011
`define ESP_BE_BYTE0 4'b1110
`define ESP_BE_BYTE1 4'b1101
`define ESP_BE_BYTE2 4'b1011
`define ESP_BE_BYTE3 4'b0111
`define ESP_BE_IDLE 4'hf
`define ESP_DEC_LSB 4
`define ESP_ADDR_LSB 2
`define ESP_ADDR_MSB 15
`define ESP_DATA_W 32
`define ESP_IRQ_W 4
`define ESP_LANES 4
`define ESP_LANE_W 8
`define ESP_SYNC_RST 2'b11
`endif

// >>> esp_edge.v
// Edge finder on a synchronised level
`timescale 1ns/1ps
module esp_edge #(
  parameter RST_VAL = 1'b0
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_reset_n,
  // Level and edges
  input wire i_level,
  output wire o_rise,
  output wire o_fall
);
  reg prev_q;
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      prev_q <= RST_VAL;
    else
      prev_q <= i_level;
  end
  assign o_rise = i_level & ~prev_q;
  assign o_fall = ~i_level & prev_q;
endmodule // esp_edge

// >>> esp_port.v
// Bus slave port: async I/O and burst DMA into the packet data path
// Functional notes
// - I/O accesses last over 180ns; no wait states are inserted.
// - DMA bursts accepted at one doubleword per bus clock.
// - Ready sampled each bus clock; cycle only when no wait requested.
// - Address bits 2 to 15 latched on address strobe trailing edge.
// - Address enable transparent while strobe low, latched on rising edge.
// - Write address valid first; data captured on write strobe trailing edge.
// - Byte enables latched on address strobe rising edge.
// - Four interrupt requests are active high, edge triggered.
// - Seven byte enable patterns select dword, word or byte.
// - Unused lanes tri-stated on reads, ignored on writes.
// - Address line 1 tied low; upper enables select the word.
// - Decode output active when address 15..4 match and enable low.
// - Bus clock is the data transfer clock during DMA bursts.
// - DMA acknowledge selects the data path without register address.
// - Direction high writes device, low reads; cycle input marks writes.
`timescale 1ns/1ps
`include "esp_defs.vh"
module esp_port #(
  parameter [11:0] BASE_ADDR = 12'h030
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_reset_n,
  // Bus address and qualifiers
  input wire [`ESP_ADDR_MSB:`ESP_ADDR_LSB] i_addr,
  input wire i_address_enable,
  input wire i_address_strobe_in_n,
  input wire [3:0] i_byte_lane_enables_n,
  // Async strobes
  input wire i_async_read_strobe_n,
  input wire i_async_write_strobe_n,
  // DMA controls
  input wire i_local_bus_clock_in,
  input wire i_direct_datapath_select_n,
  input wire i_dma_direction_in,
  input wire i_dma_cycle_in_n,
  input wire i_ready_return_in_n,
  // Data bus pins
  input wire [`ESP_DATA_W-1:0] i_data,
  output reg [`ESP_DATA_W-1:0] o_data,
  output reg [3:0] o_data_oe_n,
  // Decode and interrupts
  output reg o_local_device_decode_out_n,
  output reg [`ESP_IRQ_W-1:0] o_interrupt_request_outputs,
  // Core side
  input wire [`ESP_IRQ_W-1:0] i_core_irq,
  input wire [`ESP_DATA_W-1:0] i_core_rdata,
  output reg [`ESP_ADDR_MSB:`ESP_ADDR_LSB] o_core_addr,
  output reg [3:0] o_core_lanes,
  output reg o_core_wr,
  output reg o_core_rd,
  output reg o_core_dma,
  output reg [`ESP_DATA_W-1:0] o_core_wdata,
  output reg [15:0] o_dma_ptr
);
  // Legal pattern check and lane mask, active high lanes
  function [4:0] be_decode;
    input [3:0] be_n;
    begin
      case (be_n)
        `ESP_BE_DWORD, `ESP_BE_LOWORD, `ESP_BE_HIWORD,
        `ESP_BE_BYTE0, `ESP_BE_BYTE1, `ESP_BE_BYTE2, `ESP_BE_BYTE3:
          be_decode = {1'b1, ~be_n};
        default: be_decode = 5'h00;
      endcase
    end
  endfunction

  // Synchronised pins
  wire [9:0] sync_raw;
  wire [9:0] sync_lvl;
  assign sync_raw = {i_address_strobe_in_n, i_async_read_strobe_n, i_async_write_strobe_n,
    i_local_bus_clock_in, i_direct_datapath_select_n, i_dma_direction_in,
    i_dma_cycle_in_n, i_ready_return_in_n, i_address_enable, 1'b0};
  esp_sync #(.W(10), .RST_VAL(10'h3ae)) u_sync_ctl (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async(sync_raw),
    .o_sync(sync_lvl)
  );
  wire [`ESP_ADDR_MSB:`ESP_ADDR_LSB] addr_s;
  wire [3:0] be_s;
  wire [`ESP_DATA_W-1:0] data_s;
  esp_sync #(.W(50), .RST_VAL({14'h0, 4'hf, 32'h0})) u_sync_bus (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_async({i_addr, i_byte_lane_enables_n, i_data}),
    .o_sync({addr_s, be_s, data_s})
  );
  wire ads_s = sync_lvl[9];
  wire rd_s = sync_lvl[8];
  wire wr_s = sync_lvl[7];
  wire local_bus_clock_in_s = sync_lvl[6];
  wire dacs_s = sync_lvl[5];
  wire dir_s = sync_lvl[4];
  wire cyc_s = sync_lvl[3];
  wire rdy_s = sync_lvl[2];
  wire aen_s = sync_lvl[1];

  // Edges
  wire ads_rise;
  wire ads_fall;
  wire rd_fall;
  wire wr_rise;
  wire local_bus_clock_in_rise;
  esp_edge #(.RST_VAL(1'b1)) u_e_ads (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_level(ads_s),
    .o_rise(ads_rise),
    .o_fall(ads_fall)
  );
  esp_edge #(.RST_VAL(1'b1)) u_e_rd (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_level(rd_s),
    .o_rise(),
    .o_fall(rd_fall)
  );
  esp_edge #(.RST_VAL(1'b1)) u_e_wr (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_level(wr_s),
    .o_rise(wr_rise),
    .o_fall()
  );
  esp_edge #(.RST_VAL(1'b0)) u_e_local_bus_clock_in (
    .i_sys_clk(i_sys_clk),
    .i_reset_n(i_reset_n),
    .i_level(local_bus_clock_in_s),
    .o_rise(local_bus_clock_in_rise),
    .o_fall()
  );

  // Latched address, enable and byte lanes
  reg [`ESP_ADDR_MSB:`ESP_ADDR_LSB] addr_q;
  reg aen_q;
  reg [3:0] be_q;
  reg [`ESP_IRQ_W-1:0] irq_q;
  wire aen_eff = ads_s ? aen_q : aen_s;
  wire [4:0] be_dec = be_decode(be_q);
  wire [`ESP_DATA_W-1:0] lane_mask;
  wire dec_hit = (addr_q[`ESP_ADDR_MSB:`ESP_DEC_LSB] == BASE_ADDR) && !aen_eff;
  wire dma_act = !dacs_s;
  wire dma_fire = dma_act && local_bus_clock_in_rise && !rdy_s;
  wire io_ok = dec_hit && be_dec[4] && !dma_act;

  // Byte lane mask from the decoded enables
  genvar g;
  generate
    for (g = 0; g < `ESP_LANES; g = g + 1)
    begin : g_lane
      assign lane_mask[g*`ESP_LANE_W +: `ESP_LANE_W] = {`ESP_LANE_W{be_dec[g]}};
    end
  endgenerate

  // Address strobe capture
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      addr_q <= {(`ESP_ADDR_MSB-`ESP_ADDR_LSB+1){1'b0}};
      aen_q <= 1'b1;
      be_q <= `ESP_BE_IDLE;
    end
    else
    begin
      if (!ads_s)
        aen_q <= aen_s;
      if (ads_rise)
      begin
        addr_q <= addr_s;
        be_q <= be_s;
      end
    end
  end

  // Interrupt edge pulses, one per request line
  generate
    for (g = 0; g < `ESP_IRQ_W; g = g + 1)
    begin : g_irq
      always @(posedge i_sys_clk or negedge i_reset_n)
      begin
        if (!i_reset_n)
        begin
          irq_q[g] <= 1'b0;
          o_interrupt_request_outputs[g] <= 1'b0;
        end
        else
        begin
          irq_q[g] <= i_core_irq[g];
          o_interrupt_request_outputs[g] <= i_core_irq[g] & ~irq_q[g];
        end
      end
    end
  endgenerate

  // Local device decode
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_local_device_decode_out_n <= 1'b1;
    else
      o_local_device_decode_out_n <= ~dec_hit;
  end

  // Read data and lane drivers
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_data <= {`ESP_DATA_W{1'b0}};
      o_data_oe_n <= `ESP_BE_IDLE;
    end
    else if (io_ok && !rd_s)
    begin
      o_data <= i_core_rdata;
      o_data_oe_n <= ~be_dec[3:0];
    end
    else if (dma_act && !dir_s)
    begin
      o_data <= i_core_rdata;
      o_data_oe_n <= `ESP_BE_DWORD;
    end
    else
      o_data_oe_n <= `ESP_BE_IDLE;
  end

  // Core strobes for async I/O and burst beats
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_core_addr <= {(`ESP_ADDR_MSB-`ESP_ADDR_LSB+1){1'b0}};
      o_core_lanes <= 4'h0;
      o_core_wr <= 1'b0;
      o_core_rd <= 1'b0;
      o_core_dma <= 1'b0;
      o_core_wdata <= {`ESP_DATA_W{1'b0}};
    end
    else
    begin
      o_core_wr <= 1'b0;
      o_core_rd <= 1'b0;
      o_core_dma <= 1'b0;
      if (io_ok && rd_fall)
      begin
        o_core_addr <= addr_q;
        o_core_lanes <= be_dec[3:0];
        o_core_rd <= 1'b1;
      end
      if (io_ok && wr_rise)
      begin
        o_core_addr <= addr_q;
        o_core_lanes <= be_dec[3:0];
        o_core_wdata <= data_s & lane_mask;
        o_core_wr <= 1'b1;
      end
      if (dma_fire)
      begin
        o_core_dma <= 1'b1;
        o_core_lanes <= 4'hf;
        o_core_wr <= dir_s && !cyc_s;
        o_core_rd <= !dir_s;
        o_core_wdata <= data_s;
      end
    end
  end

  // Burst beat counter, held while ready postpones
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      o_dma_ptr <= 16'h0000;
    else if (!dma_act)
      o_dma_ptr <= 16'h0000;
    else if (dma_fire)
      o_dma_ptr <= o_dma_ptr + 16'h0001;
  end

endmodule // esp_port

// >>> esp_port_props.sv
// Checker for the bus slave port
`timescale 1ns/1ps
module esp_port_props (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_reset_n,
  // Watched pins
  input wire i_async_read_strobe_n,
  input wire i_direct_datapath_select_n,
  input wire i_ready_return_in_n,
  input wire [3:0] i_core_irq,
  input wire [3:0] o_data_oe_n,
  input wire o_local_device_decode_out_n,
  input wire [3:0] o_interrupt_request_outputs,
  input wire o_core_wr,
  input wire o_core_rd,
  input wire o_core_dma,
  input wire [15:0] o_dma_ptr
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  AST_IRQ_ONE: assert property (o_interrupt_request_outputs[0] |=> !o_interrupt_request_outputs[0])
    else $error("irq pulse long");
  AST_IRQ_SRC: assert property ($rose(o_interrupt_request_outputs[1]) |-> i_core_irq[1])
    else $error("irq without source");
  AST_WR_ONE: assert property (o_core_wr |=> !o_core_wr)
    else $error("write pulse long");
  AST_DMA_RDY: assert property (o_core_dma |-> !$past(i_ready_return_in_n, 3))
    else $error("beat while not ready");
  AST_DMA_SEL: assert property (o_core_dma |-> !$past(i_direct_datapath_select_n, 3))
    else $error("beat without select");
  AST_PTR_STEP: assert property (o_dma_ptr != $past(o_dma_ptr) && o_dma_ptr != 16'h0
    |-> o_dma_ptr == $past(o_dma_ptr) + 16'h1)
    else $error("pointer jump");
  AST_OE_OFF: assert property ((i_async_read_strobe_n && i_direct_datapath_select_n) [*5]
    |-> o_data_oe_n == 4'hf)
    else $error("lanes driven idle");
  AST_RD_HIT: assert property (o_core_rd && !o_core_dma |-> !o_local_device_decode_out_n)
    else $error("read without decode");
endmodule // esp_port_props
bind esp_port esp_port_props u_esp_port_props (.*);

// >>> esp_sync.v
// Two flop synchroniser for a bundle of pin levels
`timescale 1ns/1ps
module esp_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_reset_n,
  // Levels
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] meta_q;
  always @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      meta_q <= RST_VAL;
      o_sync <= RST_VAL;
    end
    else
    begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end
endmodule // esp_sync

// >>> tb_top.sv
// Self-checking bench for the bus slave port
`timescale 1ns/1ps
module tb_top;
  reg i_sys_clk = 0;
  reg i_reset_n = 0;
  reg [3:0] i_core_irq = 4'h0;
  reg [31:0] i_core_rdata = 32'h8421_c6e9;
  wire [15:2] i_addr, o_core_addr;
  wire i_address_enable, i_address_strobe_in_n, i_async_read_strobe_n, i_async_write_strobe_n;
  wire i_local_bus_clock_in, i_direct_datapath_select_n, i_dma_direction_in, i_dma_cycle_in_n;
  wire i_ready_return_in_n, o_local_device_decode_out_n, o_core_wr, o_core_rd, o_core_dma;
  wire [3:0] i_byte_lane_enables_n, o_data_oe_n, o_interrupt_request_outputs, o_core_lanes;
  wire [31:0] i_data, o_data, o_core_wdata, m_data;
  wire [15:0] o_dma_ptr;
  integer num_errors = 0, check_count = 0, cyc = 0, n_wr = 0, n_dma = 0, n_irq = 0, n_rdd = 0;
  reg [31:0] last_wd, q;
  reg [15:0] top_ptr = 16'h0;
  reg [3:0] qoe, irq_seen;
  localparam [27:0] PATS = {4'b0000, 4'b1100, 4'b0011, 4'b1110, 4'b1101, 4'b1011, 4'b0111};
  localparam [15:2] HIT = {12'h030, 2'h1};
  assign i_data = (o_data_oe_n == 4'hf) ? m_data : o_data;
  always #2.5 i_sys_clk = ~i_sys_clk;
  esp_port u_esp_port (.*);
  esp_bm u_esp_bm (.i_sys_clk(i_sys_clk), .i_dev_data(i_data), .i_dev_oe_n(o_data_oe_n),
    .o_addr(i_addr), .o_be_n(i_byte_lane_enables_n), .o_aen(i_address_enable),
    .o_stb_n(i_address_strobe_in_n), .o_rd_n(i_async_read_strobe_n),
    .o_wr_n(i_async_write_strobe_n), .o_bclk(i_local_bus_clock_in),
    .o_ack_n(i_direct_datapath_select_n), .o_dir(i_dma_direction_in),
    .o_cyc_n(i_dma_cycle_in_n), .o_rdy_n(i_ready_return_in_n), .o_data(m_data));
  always @(posedge i_sys_clk)
  begin
    cyc = cyc + 1;
    n_wr = n_wr + (o_core_wr === 1'b1);
    n_dma = n_dma + (o_core_dma === 1'b1);
    n_rdd = n_rdd + (o_core_dma === 1'b1 && o_core_rd === 1'b1);
    n_irq = n_irq + (o_interrupt_request_outputs !== 4'h0);
    if (o_core_wr === 1'b1)
      last_wd = o_core_wdata;
    if (o_interrupt_request_outputs !== 4'h0)
      irq_seen = o_interrupt_request_outputs;
    if (o_dma_ptr > top_ptr)
      top_ptr = o_dma_ptr;
    if (cyc == 5000)
    begin
      num_errors = num_errors + 1;
      finish_test;
    end
  end
  task check(input [31:0] got, input [31:0] exp);
  begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // Every lane pattern written then read
  task t_lanes;
    integer k;
    reg [3:0] b;
    reg [31:0] m;
  begin
    for (k = 0; k < 7; k = k + 1)
    begin
      b = PATS[k * 4 +: 4];
      m = {{8{~b[3]}}, {8{~b[2]}}, {8{~b[1]}}, {8{~b[0]}}};
      u_esp_bm.io(1, HIT, b, 0, 32'h5a3c_96e1, q, qoe);
      check(last_wd, 32'h5a3c_96e1 & m);
      check({18'h0, o_core_addr}, {18'h0, HIT});
      check({31'h0, o_local_device_decode_out_n}, 32'h0);
      u_esp_bm.io(0, HIT, b, 0, 32'h0, q, qoe);
      check({28'h0, qoe}, {28'h0, b});
      check(q & m, i_core_rdata & m);
    end
  end
  endtask
  // Bad lanes, miss and raised enable
  task t_refuse;
  begin
    u_esp_bm.io(1, HIT, 4'b1010, 0, 32'h0, q, qoe);
    u_esp_bm.io(1, 14'h3f01, 4'h0, 0, 32'h0, q, qoe);
    check({31'h0, o_local_device_decode_out_n}, 32'h1);
    u_esp_bm.io(1, HIT, 4'h0, 1, 32'h0, q, qoe);
    check(n_wr, 32'h7);
  end
  endtask
  task t_irq;
  begin
    i_core_irq = 4'hf;
    repeat (10) @(negedge i_sys_clk);
    i_core_irq = 4'h0;
    repeat (10) @(negedge i_sys_clk);
    check(n_irq, 32'h1);
    check({28'h0, irq_seen}, 32'hf);
  end
  endtask
  task t_dma;
    reg [31:0] dq;
  begin
    u_esp_bm.dma(5, 2, 1'b1, dq);
    check(n_dma, 32'h4);
    check({16'h0, top_ptr}, 32'h4);
    check(last_wd, 32'h5a00_0004);
    u_esp_bm.dma(3, 9, 1'b0, dq);
    check(n_dma, 32'h7);
    check(n_rdd, 32'h3);
    check(dq, i_core_rdata);
  end
  endtask
  task finish_test;
  begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    repeat (6) @(negedge i_sys_clk);
    i_reset_n = 1;
    repeat (4) @(negedge i_sys_clk);
    t_lanes;
    t_refuse;
    t_irq;
    t_dma;
    finish_test;
  end
endmodule // tb_top
